// File: design/bmcs_ctrl.sv
// Compare-swap control register with AXI4-Lite slave and completion interrupt.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// Contract
// - Host reaches bus-management resources only through compare-swap operations steered here.
// - Register governs the operation and chooses the resource it acts on.
// - Completion flag in bit 31 is set when a compare-swap finishes.
// - Any host write to the register clears the completion flag; here a finish in the same cycle wins and leaves the flag set.
// - Bits 30 down to 2 read as zero.
// - Selector 00 manager id, 01 bandwidth, 10 channels high, 11 channels low.
module bmcs_ctrl (
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	input  wire logic        i_swap_done,
	output logic             o_swap_start,
	output logic [3:0]       o_resource_onehot,
	output logic [1:0]       o_target_resource_select,
	output logic             o_irq
);
	// ==========================================================
	// Decoding.
	function automatic logic [3:0] bmcs_onehot(input logic [1:0] sel);
		bmcs_onehot = 4'h1 << sel;
	endfunction

	logic        compare_swap_done_reg;
	logic [1:0]  target_resource_select_reg;
	logic        irq_stat_reg;
	logic        irq_mask_reg;
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;

	wire         aw_take   = i_awvalid & o_awready;
	wire         w_take    = i_wvalid & o_wready;
	wire         aw_have   = aw_held_reg | aw_take;
	wire         w_have    = w_held_reg | w_take;
	wire         wr_fire   = aw_have & w_have & ~o_bvalid;
	wire [7:0]   wr_addr   = aw_held_reg ? awaddr_reg : i_awaddr;
	wire [31:0]  wr_data   = w_held_reg ? wdata_reg : i_wdata;
	wire [3:0]   wr_strb   = w_held_reg ? wstrb_reg : i_wstrb;
	wire         wr_ctrl   = wr_fire & (wr_addr == bmcs_pkg::OFF_CONTROL);
	wire         wr_stat   = wr_fire & (wr_addr == bmcs_pkg::OFF_IRQ_STAT);
	wire         wr_mask   = wr_fire & (wr_addr == bmcs_pkg::OFF_IRQ_MASK);
	wire         wr_known  = wr_ctrl | wr_stat | wr_mask;
	wire         rd_fire   = i_arvalid & o_arready;
	wire         rd_known  = (i_araddr == bmcs_pkg::OFF_CONTROL) |
	                         (i_araddr == bmcs_pkg::OFF_IRQ_STAT) |
	                         (i_araddr == bmcs_pkg::OFF_IRQ_MASK) |
	                         (i_araddr == bmcs_pkg::OFF_ACTIVITY);
	// Middle bits are hard zero so they can never read back as anything else.
	wire [31:0]  ctrl_view = {compare_swap_done_reg, 29'h0000_0000,
	                          target_resource_select_reg};
	wire [31:0]  rd_value  =
		(i_araddr == bmcs_pkg::OFF_CONTROL)  ? ctrl_view :
		(i_araddr == bmcs_pkg::OFF_IRQ_STAT) ? {31'h0000_0000, irq_stat_reg} :
		(i_araddr == bmcs_pkg::OFF_IRQ_MASK) ? {31'h0000_0000, irq_mask_reg} :
		(i_araddr == bmcs_pkg::OFF_ACTIVITY) ? {31'h0000_0000, ~compare_swap_done_reg} :
		32'h0000_0000;
	// Selector updates only when its byte lane is enabled; the flag clears on any control-register write.
	wire [1:0]   sel_next  = (wr_ctrl & wr_strb[0]) ?
	                         wr_data[bmcs_pkg::SEL_LSB +: bmcs_pkg::SEL_W] :
	                         target_resource_select_reg;
	// Hardware set wins over the write clear so a finish is never lost.
	wire         done_next = i_swap_done ? 1'b1 :
	                         (wr_ctrl ? 1'b0 : compare_swap_done_reg);
	wire         stat_next = i_swap_done ? 1'b1 :
	                         ((wr_stat & wr_strb[0] & wr_data[bmcs_pkg::IRQ_DONE_BIT]) ?
	                          1'b0 : irq_stat_reg);

	// ==========================================================
	// Write channel.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awaddr_reg  <= 8'h00;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			o_awready   <= 1'b0;
			o_wready    <= 1'b0;
			o_bvalid    <= 1'b0;
			o_bresp     <= 2'h0;
		end else begin
			if (aw_take) begin
				awaddr_reg <= i_awaddr;
			end
			if (w_take) begin
				wdata_reg <= i_wdata;
				wstrb_reg <= i_wstrb;
			end
			aw_held_reg <= aw_have & ~wr_fire;
			w_held_reg  <= w_have & ~wr_fire;
			// Readies drop for a cycle after every offer: one idle cycle is traded
			// for readies that stay registered and never see a combinational path.
			o_awready   <= ~aw_have & ~o_bvalid & ~wr_fire & ~o_awready;
			o_wready    <= ~w_have & ~o_bvalid & ~wr_fire & ~o_wready;
			if (wr_fire) begin
				o_bvalid <= 1'b1;
				o_bresp  <= wr_known ? bmcs_pkg::RESP_OKAY : bmcs_pkg::RESP_SLVERR;
			end else if (i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Read channel.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0000_0000;
			o_rresp   <= 2'h0;
		end else begin
			o_arready <= ~o_rvalid & ~o_arready & ~rd_fire;
			if (rd_fire) begin
				o_rvalid <= 1'b1;
				o_rdata  <= rd_value;
				o_rresp  <= rd_known ? bmcs_pkg::RESP_OKAY : bmcs_pkg::RESP_SLVERR;
			end else if (i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Control, status and interrupt.
	// A write to the control register launches the operation on the chosen resource.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			compare_swap_done_reg      <= bmcs_pkg::DONE_RESET;
			target_resource_select_reg <= bmcs_pkg::SEL_RESET;
			irq_stat_reg               <= 1'b0;
			irq_mask_reg               <= 1'b0;
			o_swap_start               <= 1'b0;
			o_target_resource_select   <= bmcs_pkg::SEL_RESET;
			o_resource_onehot          <= 4'h1;
			o_irq                      <= 1'b0;
		end else begin
			compare_swap_done_reg      <= done_next;
			target_resource_select_reg <= sel_next;
			irq_stat_reg               <= stat_next;
			if (wr_mask & wr_strb[0]) begin
				irq_mask_reg <= wr_data[bmcs_pkg::IRQ_DONE_BIT];
			end
			o_swap_start             <= wr_ctrl;
			o_target_resource_select <= sel_next;
			o_resource_onehot        <= bmcs_onehot(sel_next);
			o_irq                    <= stat_next & (wr_mask & wr_strb[0] ?
			                            wr_data[bmcs_pkg::IRQ_DONE_BIT] : irq_mask_reg);
		end
	end

	// ==========================================================
	// Checks.
	chk_done_sets: assert property (@(posedge i_clock) disable iff (i_rst)
		i_swap_done |=> compare_swap_done_reg)
		else $error("completion flag not set after finish");
	chk_write_clears: assert property (@(posedge i_clock) disable iff (i_rst)
		(wr_ctrl && !i_swap_done) |=> !compare_swap_done_reg)
		else $error("completion flag survived a write");
	chk_mid_zero: assert property (@(posedge i_clock) disable iff (i_rst)
		(rd_fire && i_araddr == bmcs_pkg::OFF_CONTROL) |=> (o_rdata[30:2] == 29'h0000_0000))
		else $error("reserved bits read nonzero");
	chk_sel_decode: assert property (@(posedge i_clock) disable iff (i_rst)
		o_resource_onehot == (4'h1 << o_target_resource_select))
		else $error("resource decode mismatch");
	chk_start_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
		wr_ctrl |=> o_swap_start ##1 !o_swap_start || $past(wr_ctrl, 1) == 1'b0)
		else $error("start pulse malformed");
	chk_sel_store: assert property (@(posedge i_clock) disable iff (i_rst)
		(wr_ctrl && wr_strb[0]) |=> target_resource_select_reg == $past(wr_data[1:0]))
		else $error("selector not stored");
	// Each answer comes one cycle after its request and leaves once it is taken.
	chk_wr_answer: assert property (@(posedge i_clock) disable iff (i_rst)
		wr_fire |=> o_bvalid)
		else $error("write answer missing");
	chk_one_write: assert property (@(posedge i_clock) disable iff (i_rst)
		wr_fire |=> !wr_fire)
		else $error("second write accepted while answer pending");
	chk_bvalid_drop: assert property (@(posedge i_clock) disable iff (i_rst)
		(o_bvalid && i_bready) |=> !o_bvalid)
		else $error("write answer stayed after it was taken");
	chk_rd_answer: assert property (@(posedge i_clock) disable iff (i_rst)
		rd_fire |=> o_rvalid)
		else $error("read answer missing");
	chk_rvalid_drop: assert property (@(posedge i_clock) disable iff (i_rst)
		(o_rvalid && i_rready) |=> !o_rvalid)
		else $error("read answer stayed after it was taken");
	chk_flag_read: assert property (@(posedge i_clock) disable iff (i_rst)
		(rd_fire && i_araddr == bmcs_pkg::OFF_CONTROL) |=>
		(o_rdata[bmcs_pkg::DONE_BIT] == $past(compare_swap_done_reg)))
		else $error("completion flag read back wrong");
	chk_flag_holds: assert property (@(posedge i_clock) disable iff (i_rst)
		(!i_swap_done && !wr_ctrl) |=> $stable(compare_swap_done_reg))
		else $error("completion flag changed without cause");
	chk_sel_kept: assert property (@(posedge i_clock) disable iff (i_rst)
		!(wr_ctrl && wr_strb[0]) |=> $stable(target_resource_select_reg))
		else $error("selector changed without a write");
	chk_stat_sets: assert property (@(posedge i_clock) disable iff (i_rst)
		i_swap_done |=> irq_stat_reg)
		else $error("finish not recorded in interrupt status");
	chk_irq_level: assert property (@(posedge i_clock) disable iff (i_rst)
		o_irq == (irq_stat_reg & irq_mask_reg))
		else $error("interrupt output disagrees with status and mask");
endmodule // bmcs_ctrl

// File: design/bmcs_pkg.sv
// Package with register map, field layout and resource codes for the compare-swap control block.
package bmcs_pkg;
	// ==========================================================
	// Register offsets (byte addresses).
	localparam logic [7:0] OFF_CONTROL  = 8'h14;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h40;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h44;
	localparam logic [7:0] OFF_ACTIVITY = 8'h48;
	// ==========================================================
	// Field layout of the control register.
	localparam int DONE_BIT = 31;
	localparam int SEL_LSB  = 0;
	localparam int SEL_W    = 2;
	// ==========================================================
	// Reset values.
	localparam logic       DONE_RESET = 1'h1;
	localparam logic [1:0] SEL_RESET  = 2'h0;
	// ==========================================================
	// Interrupt status layout: bit 0 is compare-swap finished.
	localparam int IRQ_DONE_BIT = 0;
	// ==========================================================
	// AXI responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// Resource selector codes.
	typedef enum logic [1:0] {
		BMCS_BUS_MANAGER_ID        = 2'h0,
		BMCS_BANDWIDTH_AVAILABLE   = 2'h1,
		BMCS_CHANNELS_AVAILABLE_HI = 2'h2,
		BMCS_CHANNELS_AVAILABLE_LO = 2'h3
	} bmcs_resource_e;
endpackage

// File: tb/test_bmcs_ctrl.sv
// Self-checking testbench for the compare-swap control register block.
`timescale 1ns/1ps
module test_bmcs_ctrl;
	logic        i_clock, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_swap_done;
	logic [7:0]  i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata, d, v;
	logic [3:0]  i_wstrb, o_resource_onehot;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_swap_start, o_irq, seen;
	logic [1:0]  o_bresp, o_rresp, o_target_resource_select, r, sel;
	int          n_fail = 0, check_count = 0, cycles = 0;
	bmcs_ctrl i_bmcs_ctrl (.i_clock(i_clock), .i_rst(i_rst), .i_awaddr(i_awaddr),
		.i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
		.i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
		.i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
		.o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
		.i_swap_done(i_swap_done), .o_swap_start(o_swap_start),
		.o_resource_onehot(o_resource_onehot),
		.o_target_resource_select(o_target_resource_select), .o_irq(o_irq));
	// ==========================================================
	// Helpers.
	function automatic logic [31:0] exp_ctrl(input logic f, input logic [1:0] s);
		return {f, 29'h0, s};
	endfunction
	task automatic wrap_up();
		if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Requests change just after a rising edge and are judged on what that edge sampled.
	task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s);
		@(posedge i_clock);
		i_awaddr <= a; i_awvalid <= 1'b1; i_wdata <= wd; i_wstrb <= s; i_wvalid <= 1'b1;
		i_bready <= 1'b1; seen = 1'b0;
		do begin
			@(posedge i_clock);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
			seen |= o_swap_start;
		end while (!o_bvalid);
		r = o_bresp;
		i_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clock);
		i_araddr <= a; i_arvalid <= 1'b1; i_rready <= 1'b1;
		do begin
			@(posedge i_clock);
			if (o_arready) i_arvalid <= 1'b0;
		end while (!o_rvalid);
		d = o_rdata; r = o_rresp;
		i_rready <= 1'b0;
	endtask
	// ==========================================================
	// Clock, timeout and main sequence.
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	initial begin
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_swap_done} = '0;
		i_awaddr = '0; i_araddr = '0; i_wdata = '0; i_wstrb = '0; i_rst = 1'b1;
		v = $urandom(32'h8e83);
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		rd(bmcs_pkg::OFF_CONTROL);
		chk(d, exp_ctrl(1'b1, 2'h0));
		chk({30'h0, r}, {30'h0, bmcs_pkg::RESP_OKAY});
		for (int i = 0; i < 10; i++) begin
			sel = (i < 4) ? 2'(i) : 2'($urandom);
			v = $urandom;
			v[1:0] = sel;
			wr(bmcs_pkg::OFF_CONTROL, v, 4'hF);
			chk({r, 29'h0, seen}, {bmcs_pkg::RESP_OKAY, 30'h1});
			rd(bmcs_pkg::OFF_CONTROL);
			chk(d, exp_ctrl(1'b0, sel));
			chk(32'(o_resource_onehot), 32'(4'h1 << sel));
			chk(32'(o_target_resource_select), 32'(sel));
			// The engine finishes, and software sees the flag before the next operation.
			@(posedge i_clock) i_swap_done <= 1'b1;
			@(posedge i_clock) i_swap_done <= 1'b0;
			rd(bmcs_pkg::OFF_CONTROL);
			chk(d, exp_ctrl(1'b1, sel));
		end
		rd(bmcs_pkg::OFF_ACTIVITY);
		chk(d, 32'h0);
		rd(bmcs_pkg::OFF_IRQ_STAT);
		chk(d, 32'h1);
		chk({31'h0, o_irq}, 32'h0);
		wr(bmcs_pkg::OFF_IRQ_MASK, 32'h1, 4'hF);
		repeat (2) @(negedge i_clock);
		chk({31'h0, o_irq}, 32'h1);
		wr(bmcs_pkg::OFF_IRQ_STAT, 32'h1, 4'hF);
		repeat (2) @(negedge i_clock);
		chk({31'h0, o_irq}, 32'h0);
		// Even a write with no byte enabled clears the flag but keeps the selector.
		wr(bmcs_pkg::OFF_CONTROL, {30'h0, ~sel}, 4'h0);
		rd(bmcs_pkg::OFF_CONTROL);
		chk(d, exp_ctrl(1'b0, sel));
		rd(bmcs_pkg::OFF_ACTIVITY);
		chk(d, 32'h1);
		// A finish that meets a control write in the same cycle must not be lost.
		i_swap_done <= 1'b1;
		wr(bmcs_pkg::OFF_CONTROL, 32'h0, 4'h0);
		i_swap_done <= 1'b0;
		rd(bmcs_pkg::OFF_CONTROL);
		chk(d, exp_ctrl(1'b1, sel));
		wr(8'h80, 32'h1, 4'hF);
		chk({30'h0, r}, {30'h0, bmcs_pkg::RESP_SLVERR});
		rd(8'h80);
		chk({30'h0, r}, {30'h0, bmcs_pkg::RESP_SLVERR});
		chk(d, 32'h0);
		wrap_up();
	end
endmodule // test_bmcs_ctrl
